// ### src/lcdcs_defines.svh
/*
  Constants for the common scan and power control block.
  Assumes it is included by bare name from the package file only; the modules do not include it.
*/
`ifndef LCDCS_DEFINES_SVH
`define LCDCS_DEFINES_SVH

`define LCDCS_NUM_COM       32
`define LCDCS_NUM_CHAN      129
`define LCDCS_HALF_ROWS     16
`define LCDCS_QUART         8
`define LCDCS_UPPER_BASE    24
`define LCDCS_ROWS_33       32
`define LCDCS_ROWS_17       16
`define LCDCS_PWR_BOOST     2
`define LCDCS_PWR_REG       1
`define LCDCS_PWR_FOL       0
`define LCDCS_VOL_W         6
`define LCDCS_VOL_RST       6'h00
`define LCDCS_FRAMES_PER_AC 2
`define LCDCS_ROW_CLKS      4

// Register map of the plain command port
`define LCDCS_A_SCAN        4'h0
`define LCDCS_A_PWR         4'h1
`define LCDCS_A_VOL         4'h2
`define LCDCS_A_STAT        4'h3

`endif

// ### src/lcdcs_pkg.sv
/*
  Types for the common scan and power control block.
  Assumes the defines header is on the include path.
*/
`include "lcdcs_defines.svh"
package lcdcs_pkg;
  // Drive level chosen per channel
  typedef enum logic [1:0] {LCDCS_LVL_SEL_POS, LCDCS_LVL_SEL_NEG,
                            LCDCS_LVL_UNS_POS, LCDCS_LVL_UNS_NEG} lcdcs_lvl_e;
endpackage

// ### src/lcdcs_chan.sv
/*
  One driver channel: picks one of four drive levels.
  Assumes data, scan and polarity are synchronous to sys_clk.
*/
`timescale 1ns/100ps
module lcdcs_chan
  import lcdcs_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       pix,
  input  wire logic       scan,
  input  wire logic       ac_drive_polarity,
  output lcdcs_lvl_e      level
);
  typedef struct packed {lcdcs_lvl_e level;} lcdcs_chan_s;
  lcdcs_chan_s st, next_st;

  // Selected when pixel data or common scan active
  always_comb begin
    next_st = st;
    if (pix | scan) begin                               // see RL6
      next_st.level = ac_drive_polarity ? LCDCS_LVL_SEL_NEG : LCDCS_LVL_SEL_POS;
    end else begin
      next_st.level = ac_drive_polarity ? LCDCS_LVL_UNS_NEG : LCDCS_LVL_UNS_POS;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) st <= '0;
    else     st <= next_st;
  end
  assign level = st.level;
endmodule

// ### src/lcdcs_top.sv
/*
  Common scan mapping, polarity generation and power stage enables.
  Assumes a plain command port master synchronous to sys_clk.
*/
// Our own choices: the address-and-strobe port and the placing of the registers.
// What this block does
// RL1: Host selects and holds common scan direction
// RL2: 1/33 normal: rows 0..31 on pins 0..31
// RL3: 1/33 reversed: row 31 on pin 0
// RL4: 1/17 normal: rows 0-7, 8-15 on 0-7, 24-31
// RL5: 1/17 reversed: pins 0-7 rows 15..8
// RL6: Each channel picks one of four levels
// RL7: Supply stages enabled only in master mode
// RL8: Power command updates three enables independently
// RL9: D2 booster, D1 regulator, D0 follower
// RL10: Host uses only four sensible power patterns; the block passes any of the eight, and the testbench writes all eight
// RL11: Sixty-four level contrast setting held
// RL12: Polarity alternates every two frames
// RL13: Reset: stages off, direction normal
`timescale 1ns/100ps
module lcdcs_top
  import lcdcs_pkg::*;
#(
  parameter int NUM_COM  = `LCDCS_NUM_COM,
  parameter int NUM_CHAN = `LCDCS_NUM_CHAN,
  parameter int ROW_CLKS = `LCDCS_ROW_CLKS
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic [3:0]            addr,
  input  wire logic [7:0]            wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [7:0]            rdata,
  input  wire logic                  duty_17,
  input  wire logic                  master,
  input  wire logic [NUM_CHAN-1:0]   pix_data,
  output logic      [NUM_COM-1:0]    com_scan,
  output logic                       com_icon,
  output logic                       ac_drive_polarity,
  output logic                       booster_en,
  output logic                       regulator_en,
  output logic                       follower_en,
  output logic [`LCDCS_VOL_W-1:0]    contrast,
  output lcdcs_lvl_e [NUM_CHAN-1:0]  drive_level
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic                     scan_rev;
    logic [2:0]               pwr;
    logic [`LCDCS_VOL_W-1:0]  vol;
    logic [5:0]               row;
    logic [7:0]               row_tick;
    logic                     frame_cnt;
    logic                     pol;
    logic [NUM_COM-1:0]       com;
    logic                     icon;
    logic [7:0]               rdata;
  } lcdcs_top_s;
  lcdcs_top_s st, next_st;

  logic [5:0] last_row;
  logic [4:0] pin;
  logic       pin_ok;
  assign last_row = duty_17 ? 6'(`LCDCS_ROWS_17) : 6'(`LCDCS_ROWS_33);

  // Logical row to physical pin
  always_comb begin
    pin    = '0;
    pin_ok = 1'b0;
    if (st.row < last_row) begin
      pin_ok = 1'b1;
      if (!duty_17) begin
        pin = st.scan_rev ? 5'(`LCDCS_ROWS_33 - 1 - int'(st.row))   // see RL3
                          : st.row[4:0];                            // see RL2
      end else if (!st.scan_rev) begin
        pin = (st.row < 6'(`LCDCS_QUART)) ? st.row[4:0]             // see RL4
              : 5'(int'(st.row) - `LCDCS_QUART + `LCDCS_UPPER_BASE);
      end else begin
        pin = (st.row >= 6'(`LCDCS_QUART))                          // see RL5
              ? 5'(`LCDCS_ROWS_17 - 1 - int'(st.row))
              : 5'(`LCDCS_UPPER_BASE + `LCDCS_QUART - 1 - int'(st.row));
      end
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st       = st;
    next_st.rdata = '0;
    if (wr) begin
      unique case (addr)
        `LCDCS_A_SCAN: next_st.scan_rev = wdata[0];                 // see RL1
        `LCDCS_A_PWR:  next_st.pwr = wdata[2:0];                    // see RL8
        `LCDCS_A_VOL:  next_st.vol = wdata[`LCDCS_VOL_W-1:0];       // see RL11
        default: ;
      endcase
    end
    if (rd) begin
      unique case (addr)
        `LCDCS_A_SCAN: next_st.rdata = {7'h00, st.scan_rev};
        `LCDCS_A_PWR:  next_st.rdata = {5'h00, st.pwr};
        `LCDCS_A_VOL:  next_st.rdata = {2'h0, st.vol};
        `LCDCS_A_STAT: next_st.rdata = {st.pol, master, duty_17, st.icon, 4'h0};
        default:       next_st.rdata = '0;
      endcase
    end
    // Row timing: icon row is the last slot of each frame
    if (st.row_tick == 8'(ROW_CLKS - 1)) begin
      next_st.row_tick = '0;
      // A duty change mid-frame can leave row past the new end
      if (st.row >= last_row) begin
        next_st.row = '0;
        next_st.frame_cnt = st.frame_cnt + 1'b1;
        if (st.frame_cnt == 1'(`LCDCS_FRAMES_PER_AC - 1)) begin
          next_st.pol = ~st.pol;                                    // see RL12
        end
      end else begin
        next_st.row = st.row + 6'h01;
      end
    end else begin
      next_st.row_tick = st.row_tick + 8'h01;
    end
    next_st.com = '0;
    if (pin_ok) next_st.com[pin] = 1'b1;
    next_st.icon = (st.row == last_row);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st     <= '0;                                                 // see RL13
      st.vol <= `LCDCS_VOL_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata             = st.rdata;
  assign com_scan          = st.com;
  assign com_icon          = st.icon;
  assign ac_drive_polarity = st.pol;
  assign contrast          = st.vol;
  // Slave parts take supply from the master, so enables gate here
  assign booster_en   = master & st.pwr[`LCDCS_PWR_BOOST];          // see RL7 see RL9
  assign regulator_en = master & st.pwr[`LCDCS_PWR_REG];            // see RL7 see RL9
  assign follower_en  = master & st.pwr[`LCDCS_PWR_FOL];            // see RL7 see RL9

  logic any_scan;
  assign any_scan = |st.com | st.icon;

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      lcdcs_chan u_chan (
        .sys_clk           (sys_clk),
        .rst               (rst),
        .pix               (pix_data[g]),
        .scan              (any_scan),
        .ac_drive_polarity (st.pol),
        .level             (drive_level[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_slave_power_off: assert property (@(posedge sys_clk) disable iff (rst) // see RL7
    !master |-> !(booster_en | regulator_en | follower_en))
    else $error("Stage enabled in slave mode");
  a_pwr_bits_map: assert property (@(posedge sys_clk) disable iff (rst) // see RL9
    (wr && addr == `LCDCS_A_PWR && master) |=> booster_en == $past(wdata[2])
      && regulator_en == $past(wdata[1]) && follower_en == $past(wdata[0]))
    else $error("Power bit mapping wrong");
  a_scan_held: assert property (@(posedge sys_clk) disable iff (rst) // see RL1
    !(wr && addr == `LCDCS_A_SCAN) |=> $stable(st.scan_rev))
    else $error("Scan direction changed without command");
  a_one_hot_com: assert property (@(posedge sys_clk) disable iff (rst) // see RL2
    $onehot0({com_scan, com_icon}))
    else $error("More than one common active");
  a_reserved_pins: assert property (@(posedge sys_clk) disable iff (rst) // see RL4
    duty_17 |-> com_scan[23:8] == '0 || $changed(duty_17))
    else $error("Reserved pin scanned in 1/17");
  a_pol_toggle: assert property (@(posedge sys_clk) disable iff (rst) // see RL12
    $changed(ac_drive_polarity) |-> $past(st.frame_cnt, 2) == 1'b1)
    else $error("Polarity toggled off frame pair");
  a_vol_held: assert property (@(posedge sys_clk) disable iff (rst) // see RL11
    (wr && addr == `LCDCS_A_VOL) |=> contrast == $past(wdata[5:0]))
    else $error("Contrast not stored");
  a_reset_state: assert property (@(posedge sys_clk) // see RL13
    $past(rst) |-> !booster_en && !regulator_en && !follower_en && !st.scan_rev)
    else $error("Reset state wrong");

  // ----------------------------------------
  // Checks: common mapping
  // ----------------------------------------
  a_map_norm_33: assert property (@(posedge sys_clk) disable iff (rst) // see RL2
    (!duty_17 && !st.scan_rev && st.row < 6'(`LCDCS_ROWS_33))
      |=> com_scan == NUM_COM'(1) << $past(st.row))
    else $error("Normal 1/33 row on wrong pin");

  a_map_rev_33: assert property (@(posedge sys_clk) disable iff (rst) // see RL3
    (!duty_17 && st.scan_rev && st.row < 6'(`LCDCS_ROWS_33))
      |=> com_scan == NUM_COM'(1) << (NUM_COM - 1 - $past(st.row)))
    else $error("Reversed 1/33 row on wrong pin");

  a_map_norm_lo: assert property (@(posedge sys_clk) disable iff (rst) // see RL4
    (duty_17 && !st.scan_rev && st.row < 6'(`LCDCS_QUART))
      |=> com_scan == NUM_COM'(1) << $past(st.row))
    else $error("Normal 1/17 low row on wrong pin");

  a_map_norm_hi: assert property (@(posedge sys_clk) disable iff (rst) // see RL4
    (duty_17 && !st.scan_rev && st.row >= 6'(`LCDCS_QUART)
      && st.row < 6'(`LCDCS_ROWS_17))
      |=> com_scan == NUM_COM'(1) << ($past(st.row) + `LCDCS_UPPER_BASE - `LCDCS_QUART))
    else $error("Normal 1/17 high row on wrong pin");

  a_map_rev_lo: assert property (@(posedge sys_clk) disable iff (rst) // see RL5
    (duty_17 && st.scan_rev && st.row < 6'(`LCDCS_QUART))
      |=> com_scan == NUM_COM'(1) << (NUM_COM - 1 - $past(st.row)))
    else $error("Reversed 1/17 low row on wrong pin");

  a_map_rev_hi: assert property (@(posedge sys_clk) disable iff (rst) // see RL5
    (duty_17 && st.scan_rev && st.row >= 6'(`LCDCS_QUART)
      && st.row < 6'(`LCDCS_ROWS_17))
      |=> com_scan == NUM_COM'(1) << (`LCDCS_ROWS_17 - 1 - $past(st.row)))
    else $error("Reversed 1/17 high row on wrong pin");

  a_icon_slot: assert property (@(posedge sys_clk) disable iff (rst) // see RL2
    (st.row == last_row) |=> com_icon && com_scan == '0)
    else $error("Icon slot not on icon common");

  // ----------------------------------------
  // Checks: power stages
  // ----------------------------------------
  a_pwr_held: assert property (@(posedge sys_clk) disable iff (rst) // see RL8
    !(wr && addr == `LCDCS_A_PWR) |=> $stable(st.pwr))
    else $error("Power bits changed without command");

  a_master_pass: assert property (@(posedge sys_clk) disable iff (rst) // see RL7
    master |-> booster_en == st.pwr[`LCDCS_PWR_BOOST]
      && regulator_en == st.pwr[`LCDCS_PWR_REG]
      && follower_en == st.pwr[`LCDCS_PWR_FOL])
    else $error("Master enables differ from power bits");

  // ----------------------------------------
  // Checks: command port
  // ----------------------------------------
  a_scan_write: assert property (@(posedge sys_clk) disable iff (rst) // see RL1
    (wr && addr == `LCDCS_A_SCAN) |=> st.scan_rev == $past(wdata[0]))
    else $error("Scan direction not stored");

  a_unmapped_wr: assert property (@(posedge sys_clk) disable iff (rst) // see RL1
    (wr && addr > `LCDCS_A_STAT)
      |=> $stable(st.scan_rev) && $stable(st.pwr) && $stable(st.vol))
    else $error("Unmapped write changed a setting");

  a_vol_stable: assert property (@(posedge sys_clk) disable iff (rst) // see RL11
    !(wr && addr == `LCDCS_A_VOL) |=> $stable(contrast))
    else $error("Contrast changed without command");

  a_vol_reset: assert property (@(posedge sys_clk) // see RL13
    $past(rst) |-> contrast == `LCDCS_VOL_RST)
    else $error("Contrast reset value wrong");

  // ----------------------------------------
  // Checks: levels and timing
  // ----------------------------------------
  a_level_sel: assert property (@(posedge sys_clk) disable iff (rst) // see RL6
    any_scan |=> drive_level[0] ==
      ($past(st.pol) ? LCDCS_LVL_SEL_NEG : LCDCS_LVL_SEL_POS))
    else $error("Selected level wrong for polarity");

  a_tick_bound: assert property (@(posedge sys_clk) disable iff (rst) // see RL12
    st.row_tick < 8'(ROW_CLKS))
    else $error("Row tick out of range");

  a_pol_on_frame: assert property (@(posedge sys_clk) disable iff (rst) // see RL12
    $changed(ac_drive_polarity) |-> $past(st.row) == $past(last_row))
    else $error("Polarity flipped inside a frame");
endmodule

// ### testbench/lcdcs_pm.sv
/*
  Panel rows model: logs scanned pins, times polarity flips.
  Assumes one-hot com_scan synchronous to sys_clk.
*/
`timescale 1ns/100ps
module lcdcs_pm (
  input  wire logic        sys_clk,
  input  wire logic [31:0] com_scan,
  input  wire logic        ac_drive_polarity,
  output logic [128:0]     pix_data
);
  // ----------
  // Row log
  // ----------
  int   seen[$];
  int   cyc      = 0;
  int   flip_len = 0;
  logic pol_d    = 1'b0;
  initial pix_data = 129'h1;
  // Log a pin once per row, not once per clock
  always @(posedge sys_clk) begin
    if (com_scan != 32'h0 && (seen.size() == 0 || (32'h1 << seen[$]) != com_scan))
      seen.push_back($clog2(com_scan));
    cyc <= cyc + 1;
    if (ac_drive_polarity != pol_d) begin
      flip_len <= cyc;
      cyc <= 1;
    end
    pol_d <= ac_drive_polarity;
    pix_data <= {pix_data[127:0], ~pix_data[128]};
  end
endmodule

// ### testbench/lcdcs_top_tb.sv
/*
  Testbench: command port tasks, scan order, power and contrast.
  Assumes the package is compiled first.
*/
`timescale 1ns/100ps
module lcdcs_top_tb
  import lcdcs_pkg::*;
;
  // ----------
  // Setup
  // ----------
  localparam int RC = 2;
  localparam logic [7:0] PATS [3] = '{8'h07, 8'h03, 8'h01};
  logic sys_clk, rst, wr, rd, duty_17, master;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [128:0] pix_data;
  logic [31:0] com_scan;
  logic com_icon, ac_drive_polarity, booster_en, regulator_en, follower_en;
  logic [5:0] contrast;
  lcdcs_lvl_e [128:0] lvl;
  int n_fail   = 0;
  int compares = 0;
  lcdcs_top #(.ROW_CLKS(RC)) lcdcs_top_i (.sys_clk(sys_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .duty_17(duty_17), .master(master),
    .pix_data(pix_data), .com_scan(com_scan), .com_icon(com_icon),
    .ac_drive_polarity(ac_drive_polarity), .booster_en(booster_en),
    .regulator_en(regulator_en), .follower_en(follower_en), .contrast(contrast),
    .drive_level(lvl));
  lcdcs_pm lcdcs_pm_i (.sys_clk(sys_clk), .com_scan(com_scan),
    .ac_drive_polarity(ac_drive_polarity), .pix_data(pix_data));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ----------
  // Tasks
  // ----------
  task automatic stop_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Data stands one cycle only, so look just after the edge
  task automatic rd_reg(input logic [3:0] a, input string nm, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
    @(posedge sys_clk);
  endtask
  task automatic wait_icon();
    for (int i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      if (com_icon === 1'b1)
        return;
    end
    chk("icon wait", 1, 0);
    stop_test();
  endtask
  task automatic wait_frame();
    wait_icon();
    @(posedge sys_clk);
    lcdcs_pm_i.seen.delete();
    repeat (RC + 1) @(posedge sys_clk);
    wait_icon();
  endtask
  task automatic scan_test(input logic d17, input logic rev);
    int n;
    int p;
    n = d17 ? 16 : 32;
    duty_17 <= d17;
    wr_reg(4'h0, {7'h00, rev});
    repeat (2) wait_frame();
    chk("rows", n, lcdcs_pm_i.seen.size());
    for (int r = 0; r < n; r++) begin
      if (!d17)
        p = rev ? 31 - r : r;
      else
        p = rev ? (r < 8 ? 31 - r : 15 - r) : (r < 8 ? r : r + 16);
      chk("pin", p, lcdcs_pm_i.seen[r]);
    end
    $display("scan test done");
  endtask
  // ----------
  // Tests
  // ----------
  initial begin
    rst <= 1'b1;
    {addr, wdata, wr, rd, duty_17} <= '0;
    master <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("stages", 0, {booster_en, regulator_en, follower_en});
    rd_reg(4'h0, "dir", 8'h00);
    repeat (6) wait_frame();
    chk("flip", 2 * 33 * RC, lcdcs_pm_i.flip_len);
    scan_test(1'b0, 1'b0);
    scan_test(1'b0, 1'b1);
    scan_test(1'b1, 1'b0);
    scan_test(1'b1, 1'b1);
    for (int v = 0; v < 8; v++) begin
      wr_reg(4'h1, v[7:0]);
      chk("stages", v[2:0], {booster_en, regulator_en, follower_en});
      rd_reg(4'h1, "pwr", v[7:0]);
    end
    // Recommended patterns: enables stay off while slave, then follow the bits once master
    foreach (PATS[k]) begin
      master <= 1'b0;
      wr_reg(4'h1, PATS[k]);
      chk("slave", 0, {booster_en, regulator_en, follower_en});
      master <= 1'b1;
      @(posedge sys_clk);
      chk("master", PATS[k], {booster_en, regulator_en, follower_en});
    end
    $display("power test done");
    wr_reg(4'h2, 8'h3F);
    chk("contrast", 6'h3F, contrast);
    wr_reg(4'hF, 8'hFF);
    rd_reg(4'hF, "unmapped", 8'h00);
    rd_reg(4'h2, "contrast", 8'h3F);
    $display("contrast test done");
    begin
      logic p;
      @(posedge sys_clk);
      #1 p = ac_drive_polarity;
      @(posedge sys_clk);
      #1 chk("level", {31'h0, p}, 32'(lvl[5]));
    end
    $display("level test done");
    stop_test();
  end
endmodule
